// ---- design/ccr_pkg.sv ----
// Purpose: Shared constants for the coupler channel register block
// Assumes: Register-number addressing, 16-bit register data
// Notes: Reset values apply only on a factory or general reset
package ccr_pkg;
    localparam int CCR_REG_AW = 6;
    localparam int CCR_REG_DW = 16;
    localparam logic [5:0] CCR_ADDR_PUBLISH = 6'h0E;
    localparam logic [5:0] CCR_ADDR_RATE = 6'h16;
    localparam logic [5:0] CCR_ADDR_FRAMING = 6'h17;
    localparam logic [5:0] CCR_ADDR_STOP = 6'h18;
    localparam logic [5:0] CCR_ADDR_RATE_V2 = 6'h20;
    localparam logic [5:0] CCR_ADDR_FRAMING_V2 = 6'h21;
    localparam logic [15:0] CCR_RST_PUBLISH = 16'h0000;
    localparam logic [15:0] CCR_RST_RATE = 16'h0001;
    localparam logic [15:0] CCR_RST_FRAMING = 16'h0003;
    localparam logic [15:0] CCR_RST_STOP = 16'h0000;
    localparam logic [15:0] CCR_RST_RATE_V2 = 16'h0002;
    localparam logic [15:0] CCR_RST_FRAMING_V2 = 16'h0002;
    localparam int CCR_PUBLISH_BIT = 10;
    localparam logic [7:0] CCR_NO_ADDRESS = 8'h00;
    localparam logic [7:0] CCR_SERIAL_MODE = 8'd99;
    localparam int CCR_CTRL_ACCESS_BIT = 7;
    localparam int CCR_LOW_RES_BITS = 12;
    localparam logic [2:0] CCR_RATE_MAX = 3'd6;
    localparam logic [2:0] CCR_FRAMING_MAX = 3'd4;
    // Baud rate codes
    localparam logic [2:0] CCR_BAUD_38400 = 3'd0;
    localparam logic [2:0] CCR_BAUD_19200 = 3'd1;
    localparam logic [2:0] CCR_BAUD_9600 = 3'd2;
    localparam logic [2:0] CCR_BAUD_57600 = 3'd3;
    localparam logic [2:0] CCR_BAUD_1200 = 3'd4;
    localparam logic [2:0] CCR_BAUD_2400 = 3'd5;
    localparam logic [2:0] CCR_BAUD_4800 = 3'd6;
    typedef enum logic [1:0] {CCR_PAR_NONE, CCR_PAR_EVEN, CCR_PAR_ODD} ccr_parity_type;
endpackage

// ---- design/ccr_channel.sv ----
// Purpose: One analog channel: process-image word, control/status byte, 64 registers
// Assumes: Control byte comes from logic on the same clock
// Notes: Register set is kept in a local array
`timescale 1ns/1ps
module ccr_channel
    import ccr_pkg::*;
#(
    parameter int RES_BITS = 15
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [7:0] ctrl_byte,
    input wire logic [15:0] out_word,
    input wire logic out_strobe,
    input wire logic [14:0] adc_mag,
    input wire logic adc_sign,
    output logic [15:0] in_word,
    output logic [7:0] status_byte,
    output logic [15:0] analog_out
);
    initial begin
        if (RES_BITS < 1 || RES_BITS > 15) $error("RES_BITS out of range");
    end

    typedef struct packed {
        logic [15:0] in_word;
        logic [7:0] status;
        logic [15:0] analog;
    } ccr_ch_state_type;

    ccr_ch_state_type s_q, s_d;
    logic [15:0] regs_q [64];
    logic access_mode;
    logic [5:0] reg_addr;
    logic [15:0] sample;

    assign access_mode = ctrl_byte[CCR_CTRL_ACCESS_BIT];
    assign reg_addr = ctrl_byte[5:0];

    // Sign plus 15-bit magnitude; unresolved low bits forced to zero
    always_comb begin
        sample = {adc_sign, adc_mag};
        for (int i = 0; i < 15 - RES_BITS; i++) begin
            sample[i] = 1'b0;
        end
    end

    always_comb begin
        s_d = s_q;
        if (access_mode) begin
            s_d.in_word = regs_q[reg_addr];
        end else begin
            s_d.in_word = sample;
            if (out_strobe) begin
                s_d.analog = out_word;
            end
        end
        s_d.status = {access_mode, 1'b0, reg_addr};
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    // Parameter registers are not reset, as they would be retained
    always_ff @(posedge clk) begin
        if (ce && access_mode && out_strobe) begin
            regs_q[reg_addr] <= out_word;
        end
    end

    assign in_word = s_q.in_word;
    assign status_byte = s_q.status;
    assign analog_out = s_q.analog;

    a_status_echo: assert property (@(posedge clk) disable iff (!rst_n)
        ce |=> status_byte[5:0] == $past(ctrl_byte[5:0]))
        else $error("status byte does not echo register address");
endmodule

// ---- design/ccr_coupler.sv ----
// Purpose: Coupler configuration registers and one analog channel
// Assumes: Register port from same-clock host logic; mode input from pins
// Notes: Defaults load only on factory reset or asynchronous NRST
`timescale 1ns/1ps
module ccr_coupler
    import ccr_pkg::*;
#(
    parameter bit USE_V2_REGS = 1'b1,
    parameter int CH_RES_BITS = 15
) (
    input wire logic SYS_CLK,
    input wire logic NRST,
    input wire logic CE,
    input wire logic FACTORY_RESET,
    input wire logic [7:0] OP_MODE_PIN,
    input wire logic [7:0] NODE_ADDRESS,
    input wire logic REG_WR,
    input wire logic [5:0] REG_ADDR,
    input wire logic [15:0] REG_WDATA,
    output logic [15:0] REG_RDATA,
    output logic REG_ACK,
    output logic REG_REFUSED,
    input wire logic THIRD_BYTE_EN,
    input wire logic [7:0] CH_CTRL_BYTE,
    input wire logic [15:0] CH_OUT_WORD,
    input wire logic CH_OUT_STROBE,
    input wire logic [14:0] CH_ADC_MAG,
    input wire logic CH_ADC_SIGN,
    output logic [23:0] CH_IMAGE_IN,
    output logic [4:0] CH_IMAGE_BYTES,
    output logic [15:0] CH_ANALOG_OUT,
    output logic [2:0] BAUD_CODE,
    output logic [3:0] DATA_BITS,
    output logic [1:0] PARITY,
    output logic [1:0] STOP_BITS,
    output logic [7:0] ACTIVE_ADDRESS_FLAG_BYTE
);
    initial begin
        if (CH_RES_BITS < 1 || CH_RES_BITS > 15) $error("CH_RES_BITS out of range");
    end

    typedef struct packed {
        logic [7:0] mode_s1;
        logic [7:0] mode_s2;
        logic [15:0] publish;
        logic [15:0] rate;
        logic [15:0] framing;
        logic [15:0] stop;
        logic [15:0] rate_v2;
        logic [15:0] framing_v2;
        logic [15:0] rdata;
        logic ack;
        logic refused;
        logic [7:0] flag;
        logic [2:0] baud;
        logic [3:0] dbits;
        logic [1:0] parity;
        logic [1:0] sbits;
    } ccr_state_type;

    ccr_state_type s_q, s_d;
    logic [15:0] ch_in_word;
    logic [7:0] ch_status;
    logic serial_open;
    logic [2:0] rate_sel;
    logic [2:0] framing_sel;

    function automatic logic [2:0] clip_code(input logic [15:0] v, input logic [2:0] max,
                                             input logic [2:0] fallback);
        clip_code = (v > {13'h0, max}) ? fallback : v[2:0];
    endfunction

    ccr_channel #(
        .RES_BITS(CH_RES_BITS)
    ) u_channel (
        .clk(SYS_CLK),
        .rst_n(NRST),
        .ce(CE),
        .ctrl_byte(CH_CTRL_BYTE),
        .out_word(CH_OUT_WORD),
        .out_strobe(CH_OUT_STROBE),
        .adc_mag(CH_ADC_MAG),
        .adc_sign(CH_ADC_SIGN),
        .in_word(ch_in_word),
        .status_byte(ch_status),
        .analog_out(CH_ANALOG_OUT)
    );

    // Only serial settings are locked outside mode 99
    assign serial_open = (s_q.mode_s2 == CCR_SERIAL_MODE);

    assign rate_sel = USE_V2_REGS ? clip_code(s_q.rate_v2, CCR_RATE_MAX, CCR_BAUD_9600)
                                  : clip_code(s_q.rate, CCR_RATE_MAX, CCR_BAUD_19200);
    assign framing_sel = USE_V2_REGS ? clip_code(s_q.framing_v2, CCR_FRAMING_MAX, 3'd2)
                                     : clip_code(s_q.framing, CCR_FRAMING_MAX, 3'd3);

    always_comb begin
        s_d = s_q;
        s_d.mode_s1 = OP_MODE_PIN;
        s_d.mode_s2 = s_q.mode_s1;
        s_d.ack = 1'b0;
        s_d.refused = 1'b0;
        if (FACTORY_RESET) begin
            s_d.publish = CCR_RST_PUBLISH;
            s_d.rate = CCR_RST_RATE;
            s_d.framing = CCR_RST_FRAMING;
            s_d.stop = CCR_RST_STOP;
            s_d.rate_v2 = CCR_RST_RATE_V2;
            s_d.framing_v2 = CCR_RST_FRAMING_V2;
        end else if (REG_WR) begin
            s_d.ack = 1'b1;
            case (REG_ADDR)
                CCR_ADDR_PUBLISH: s_d.publish = REG_WDATA;
                CCR_ADDR_RATE: if (serial_open) s_d.rate = REG_WDATA; else s_d.refused = 1'b1;
                CCR_ADDR_FRAMING: if (serial_open) s_d.framing = REG_WDATA;
                                  else s_d.refused = 1'b1;
                CCR_ADDR_STOP: if (serial_open) s_d.stop = REG_WDATA; else s_d.refused = 1'b1;
                CCR_ADDR_RATE_V2: if (serial_open) s_d.rate_v2 = REG_WDATA;
                                  else s_d.refused = 1'b1;
                CCR_ADDR_FRAMING_V2: if (serial_open) s_d.framing_v2 = REG_WDATA;
                                     else s_d.refused = 1'b1;
                default: s_d.refused = 1'b1;
            endcase
        end else begin
            s_d.ack = 1'b1;
            case (REG_ADDR)
                CCR_ADDR_PUBLISH: s_d.rdata = s_q.publish;
                CCR_ADDR_RATE: s_d.rdata = s_q.rate;
                CCR_ADDR_FRAMING: s_d.rdata = s_q.framing;
                CCR_ADDR_STOP: s_d.rdata = s_q.stop;
                CCR_ADDR_RATE_V2: s_d.rdata = s_q.rate_v2;
                CCR_ADDR_FRAMING_V2: s_d.rdata = s_q.framing_v2;
                default: s_d.rdata = 16'h0000;
            endcase
        end
        s_d.baud = rate_sel;
        case (framing_sel)
            3'd0: begin s_d.dbits = 4'd7; s_d.parity = CCR_PAR_EVEN; end
            3'd1: begin s_d.dbits = 4'd7; s_d.parity = CCR_PAR_ODD; end
            3'd2: begin s_d.dbits = 4'd8; s_d.parity = CCR_PAR_NONE; end
            3'd3: begin s_d.dbits = 4'd8; s_d.parity = CCR_PAR_EVEN; end
            default: begin s_d.dbits = 4'd8; s_d.parity = CCR_PAR_ODD; end
        endcase
        s_d.sbits = s_q.stop[0] ? 2'd2 : 2'd1;
        s_d.flag = s_q.publish[CCR_PUBLISH_BIT] ? NODE_ADDRESS : CCR_NO_ADDRESS;
    end

    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            s_q <= '0;
            s_q.rate <= CCR_RST_RATE;
            s_q.framing <= CCR_RST_FRAMING;
            s_q.stop <= CCR_RST_STOP;
            s_q.rate_v2 <= CCR_RST_RATE_V2;
            s_q.framing_v2 <= CCR_RST_FRAMING_V2;
            s_q.publish <= CCR_RST_PUBLISH;
            s_q.baud <= USE_V2_REGS ? CCR_BAUD_9600 : CCR_BAUD_19200;
            s_q.dbits <= 4'd8;
            s_q.parity <= USE_V2_REGS ? CCR_PAR_NONE : CCR_PAR_EVEN;
            s_q.sbits <= 2'd1;
        end else if (CE) begin
            s_q <= s_d;
        end
    end

    // Third byte appended only when the option is on
    assign CH_IMAGE_IN = THIRD_BYTE_EN ? {ch_in_word, ch_status}
                                       : {8'h00, ch_in_word};
    assign CH_IMAGE_BYTES = THIRD_BYTE_EN ? 5'd3 : 5'd2;
    assign REG_RDATA = s_q.rdata;
    assign REG_ACK = s_q.ack;
    assign REG_REFUSED = s_q.refused;
    assign BAUD_CODE = s_q.baud;
    assign DATA_BITS = s_q.dbits;
    assign PARITY = s_q.parity;
    assign STOP_BITS = s_q.sbits;
    assign ACTIVE_ADDRESS_FLAG_BYTE = s_q.flag;

    sequence wr_locked;
        REG_WR && !FACTORY_RESET && !serial_open && REG_ADDR == CCR_ADDR_RATE_V2;
    endsequence

    a_locked_rate: assert property (@(posedge SYS_CLK) disable iff (!NRST)
        (CE and wr_locked) |=> s_q.rate_v2 == $past(s_q.rate_v2) && REG_REFUSED)
        else $error("rate changed outside mode 99");
    a_factory_rate: assert property (@(posedge SYS_CLK) disable iff (!NRST)
        CE && FACTORY_RESET |=> s_q.rate == 16'h0001 && s_q.rate_v2 == 16'h0002)
        else $error("baud defaults wrong after factory reset");
    a_factory_framing: assert property (@(posedge SYS_CLK) disable iff (!NRST)
        CE && FACTORY_RESET |=> s_q.framing == 16'h0003 && s_q.framing_v2 == 16'h0002)
        else $error("framing defaults wrong after factory reset");
    a_stop_decode: assert property (@(posedge SYS_CLK) disable iff (!NRST)
        CE && s_q.stop[0] |=> STOP_BITS == 2'd2)
        else $error("stop bit decode wrong");
    a_framing_none: assert property (@(posedge SYS_CLK) disable iff (!NRST)
        CE && framing_sel == 3'd2 |=> DATA_BITS == 4'd8 && PARITY == CCR_PAR_NONE)
        else $error("framing code 2 decode wrong");
    a_flag_publish: assert property (@(posedge SYS_CLK) disable iff (!NRST)
        CE && s_q.publish[10] |=> ACTIVE_ADDRESS_FLAG_BYTE == $past(NODE_ADDRESS))
        else $error("active address not published");
    a_flag_silent: assert property (@(posedge SYS_CLK) disable iff (!NRST)
        CE && !s_q.publish[10] |=> ACTIVE_ADDRESS_FLAG_BYTE == 8'h00)
        else $error("address published while disabled");
    a_image_third: assert property (@(posedge SYS_CLK) disable iff (!NRST)
        THIRD_BYTE_EN |-> CH_IMAGE_BYTES == 5'd3 && CH_IMAGE_IN[7:0] == ch_status)
        else $error("third byte missing from image");
    a_baud_hold: assert property (@(posedge SYS_CLK) disable iff (!NRST)
        !CE |=> BAUD_CODE == $past(BAUD_CODE))
        else $error("baud code moved while frozen");
endmodule

// ---- testbench/ccr_host_model.sv ----
// Purpose: Configuration host facing the coupler register port
// Assumes: Bench changes request fields by non-blocking assignment at the rising edge
// Notes: Every enabled cycle is an access, so a request is held as a read when idle
`timescale 1ns/1ps
module ccr_host_model
    import ccr_pkg::*;
(
    input wire logic open_mode,
    input wire logic wr,
    input wire logic [5:0] addr,
    input wire logic [15:0] wdata,
    output logic [7:0] op_mode,
    output logic reg_wr,
    output logic [5:0] reg_addr,
    output logic [15:0] reg_wdata
);
    // Mode 99 shows only while open_mode is set; writes to serial settings pass through in either mode
    assign op_mode = open_mode ? CCR_SERIAL_MODE : 8'h00;
    assign reg_wr = wr;
    assign reg_addr = addr;
    assign reg_wdata = wdata;
endmodule

// ---- testbench/coupler_channel_register_config_tb.sv ----
// Purpose: Self-checking bench for the coupler registers and one channel
// Assumes: Default parameters, so registers 32/33 hold baud rate and framing
// Notes: Random values come from a fixed-seed shift register
`timescale 1ns/1ps
module coupler_channel_register_config_tb
    import ccr_pkg::*;
;
    logic sys_clk = 1'b0, nrst = 1'b0, ce = 1'b1, fr = 1'b0, open_m = 1'b0, h_wr = 1'b0;
    logic third = 1'b0, strobe = 1'b0, sgn = 1'b0;
    logic [5:0] h_addr = 6'h00;
    logic [15:0] h_wd = 16'h0000, wout = 16'h0000, rd, v0;
    logic [7:0] node = 8'h00, ctrl = 8'h00, op_mode;
    logic [14:0] mag = 15'h0000;
    logic reg_wr, ack, refused, ref_s;
    logic [5:0] reg_addr, a;
    logic [15:0] reg_wdata, rdata, aout;
    logic [23:0] img;
    logic [4:0] nbytes;
    logic [2:0] baud;
    logic [3:0] dbits;
    logic [1:0] par, stopb;
    logic [7:0] flag;
    logic [31:0] rnd = 32'd72031;
    logic [5:0] ra [6] = '{CCR_ADDR_PUBLISH, CCR_ADDR_RATE, CCR_ADDR_FRAMING, CCR_ADDR_STOP,
                           CCR_ADDR_RATE_V2, CCR_ADDR_FRAMING_V2};
    logic [15:0] rv [6] = '{CCR_RST_PUBLISH, CCR_RST_RATE, CCR_RST_FRAMING, CCR_RST_STOP,
                            CCR_RST_RATE_V2, CCR_RST_FRAMING_V2};
    int n_mismatch = 0, tests_run = 0, cyc = 0;
    always #25 sys_clk = ~sys_clk;
    ccr_host_model ccr_host_model_i (.open_mode(open_m), .wr(h_wr), .addr(h_addr),
        .wdata(h_wd), .op_mode(op_mode), .reg_wr(reg_wr), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata));
    ccr_coupler ccr_coupler_i (.SYS_CLK(sys_clk), .NRST(nrst), .CE(ce), .FACTORY_RESET(fr),
        .OP_MODE_PIN(op_mode), .NODE_ADDRESS(node), .REG_WR(reg_wr), .REG_ADDR(reg_addr),
        .REG_WDATA(reg_wdata), .REG_RDATA(rdata), .REG_ACK(ack), .REG_REFUSED(refused),
        .THIRD_BYTE_EN(third), .CH_CTRL_BYTE(ctrl), .CH_OUT_WORD(wout),
        .CH_OUT_STROBE(strobe), .CH_ADC_MAG(mag), .CH_ADC_SIGN(sgn), .CH_IMAGE_IN(img),
        .CH_IMAGE_BYTES(nbytes), .CH_ANALOG_OUT(aout), .BAUD_CODE(baud), .DATA_BITS(dbits),
        .PARITY(par), .STOP_BITS(stopb), .ACTIVE_ADDRESS_FLAG_BYTE(flag));
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [3:0] exp_bits(input int c);
        return (c < 2) ? 4'h7 : 4'h8;
    endfunction
    // Parity code: 0 none, 1 even, 2 odd
    function automatic logic [1:0] exp_par(input int c);
        return (c == 2) ? 2'h0 : ((c == 0 || c == 3) ? 2'h1 : 2'h2);
    endfunction
    task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] got);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("FAIL %s expected %h seen %h", name, exp, got);
        end
    endtask
    // Access taken on the second edge; its answer stands just after that edge
    task automatic acc(input logic wr, input logic [5:0] ad, input logic [15:0] wd);
        @(posedge sys_clk);
        h_wr <= wr;
        h_addr <= ad;
        h_wd <= wd;
        @(posedge sys_clk);
        #1;
        rd = rdata;
        ref_s = refused;
        chk("ack", 1, ack);
        h_wr <= 1'b0;
    endtask
    task automatic ch(input logic [7:0] c, input logic st, input logic [15:0] w);
        @(posedge sys_clk);
        ctrl <= c;
        strobe <= st;
        wout <= w;
        @(posedge sys_clk);
        strobe <= 1'b0;
        @(posedge sys_clk);
        #1;
    endtask
    task automatic settle();
        @(posedge sys_clk);
        #1;
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_mismatch++;
            complete_run();
        end
    end
    initial begin
        repeat (4) @(posedge sys_clk);
        nrst <= 1'b1;
        #1;
        chk("baud_rst", CCR_BAUD_9600, baud);
        chk("bits_rst", 8, dbits);
        chk("par_rst", 0, par);
        chk("stop_rst", 1, stopb);
        chk("flag_rst", 0, flag);
        for (int i = 0; i < 6; i++) begin
            acc(1'b0, ra[i], 16'h0000);
            chk("reg_rst", rv[i], rd);
        end
        acc(1'b1, CCR_ADDR_RATE_V2, 16'h0005);
        chk("locked", 1, ref_s);
        acc(1'b0, CCR_ADDR_RATE_V2, 16'h0000);
        chk("locked_val", CCR_RST_RATE_V2, rd);
        $display("test reset and lock done");
        open_m <= 1'b1;
        repeat (3) @(posedge sys_clk);
        for (int c = 0; c < 7; c++) begin
            acc(1'b1, CCR_ADDR_RATE_V2, 16'(c));
            settle();
            chk("baud", c, baud);
        end
        for (int c = 0; c < 5; c++) begin
            acc(1'b1, CCR_ADDR_FRAMING_V2, 16'(c));
            settle();
            chk("bits", exp_bits(c), dbits);
            chk("par", exp_par(c), par);
        end
        for (int c = 0; c < 2; c++) begin
            acc(1'b1, CCR_ADDR_STOP, 16'(c));
            settle();
            chk("stop", c + 1, stopb);
        end
        acc(1'b1, 6'h3F, 16'hFFFF);
        chk("unmapped_wr", 1, ref_s);
        acc(1'b0, 6'h3F, 16'h0000);
        chk("unmapped_rd", 0, rd);
        $display("test serial settings done");
        rnd = lfsr_next(rnd);
        node <= rnd[7:0] | 8'h01;
        acc(1'b1, CCR_ADDR_PUBLISH, 16'h0400);
        settle();
        chk("flag_on", node, flag);
        acc(1'b1, CCR_ADDR_PUBLISH, 16'h0000);
        settle();
        chk("flag_off", 0, flag);
        @(posedge sys_clk);
        fr <= 1'b1;
        @(posedge sys_clk);
        fr <= 1'b0;
        repeat (2) settle();
        chk("baud_factory", CCR_BAUD_9600, baud);
        chk("stop_factory", 1, stopb);
        @(posedge sys_clk);
        ce <= 1'b0;
        h_wr <= 1'b1;
        h_addr <= CCR_ADDR_RATE_V2;
        h_wd <= 16'h0005;
        repeat (3) settle();
        chk("baud_frozen", CCR_BAUD_9600, baud);
        @(posedge sys_clk);
        h_wr <= 1'b0;
        ce <= 1'b1;
        settle();
        $display("test publish and factory done");
        for (int k = 0; k < 4; k++) begin
            rnd = lfsr_next(rnd);
            mag <= rnd[14:0];
            sgn <= rnd[15];
            third <= k[0];
            ch(8'h00, 1'b1, rnd[31:16]);
            chk("analog_out", rnd[31:16], aout);
            chk("image", k[0] ? {rnd[15:0], 8'h00} : {8'h00, rnd[15:0]}, img);
            chk("bytes", k[0] ? 3 : 2, nbytes);
        end
        third <= 1'b1;
        rnd = lfsr_next(rnd);
        v0 = rnd[15:0];
        ch(8'h80, 1'b1, v0);
        for (int k = 0; k < 4; k++) begin
            rnd = lfsr_next(rnd);
            a = (k == 0) ? 6'h3F : (rnd[21:16] | 6'h01);
            ch({2'b10, a}, 1'b1, rnd[15:0]);
            chk("reg_access", {rnd[15:0], 2'b10, a}, img);
        end
        ch(8'h80, 1'b0, 16'h0000);
        chk("reg_retained", {v0, 8'h80}, img);
        $display("test channel done");
        complete_run();
    end
endmodule
